// *** core/sdram_seq_pkg.sv ***
// Constants, command codes, state type and the mode word for the SDRAM
// init and refresh sequencer. Assumes a single 40 MHz clock.
package sdram_seq_pkg;

    // ----------------------------------------------------------------
    // Timing.
    // ----------------------------------------------------------------
    localparam int CLK_NS = 25;                  // Clock period in ns.
    localparam int REFRESH_NS = 8200;            // Refresh interval, 8.2 us.
    localparam int REFRESH_CYC = REFRESH_NS / CLK_NS; // Longest time, rounded down.
    localparam int GAP_NS = 100;                 // Least spacing between init commands.
    localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS; // Least time, rounded up.
    localparam int INIT_REFRESHES = 8;           // Auto-refreshes during bring-up.
    localparam int ROWS = 4096;                  // Rows to cover per window.
    localparam int RETENTION_US = 34000;         // Retention window, 34 ms.
    localparam int MARGIN_US = 30000;            // Redundancy kept in the window.
    localparam int CAS_LAT = 3;                  // Read data delay after CAS.
    localparam int PROC_SHIFT = 3;               // SDRAM A0 lands on processor A28.
    // A full sweep of all rows must fit the retention window.
    localparam bit SWEEP_FITS = (ROWS * (REFRESH_NS / 1000)) <= RETENTION_US;

    // ----------------------------------------------------------------
    // Mode register fields.
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_RSV = 2'h0;      // Reserved pairs, always zero.
    localparam logic [2:0] MODE_CL = 3'h3;       // CAS latency three.
    localparam logic MODE_BT = 1'h0;             // Sequential burst order.
    localparam logic [2:0] MODE_BL = 3'h2;       // Four-beat bursts.

    // ----------------------------------------------------------------
    // Commands as {cs_n, ras_n, cas_n, we_n}.
    // ----------------------------------------------------------------
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam int PRE_ALL_BIT = 10;             // Address bit selecting all banks.

    // ----------------------------------------------------------------
    // Register map, byte offsets, bit positions and reset values.
    // ----------------------------------------------------------------
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [3:0] RCNT_OFS = 4'h8;
    localparam logic [3:0] MODE_OFS = 4'hc;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_WB_BIT = 1;
    localparam int CTRL_REN_BIT = 2;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_INIT_BIT = 1;
    localparam int STAT_PEND_LSB = 4;
    localparam int STAT_OVF_BIT = 8;
    localparam logic CTRL_WB_RST = 1'h0;
    localparam logic CTRL_REN_RST = 1'h1;
    localparam logic [3:0] PEND_MAX = 4'hf;

    // Sequencer states.
    typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_REF, ST_MRS, ST_RUN} seq_state_type;

    // Builds the mode word from the write-burst choice.
    // Mode word fields.
    function automatic logic [11:0] mode_word(input logic wb_single);
        return {MODE_RSV, wb_single, MODE_RSV, MODE_CL, MODE_BT, MODE_BL};
    endfunction

endpackage

// *** core/refresh_timer.sv ***
// Periodic refresh timer: one tick every refresh interval while run is high.
// Assumes run comes from logic on the same clock.
`timescale 1ns/10ps
module refresh_timer
    import sdram_seq_pkg::*;
(
    input wire logic clk,       // System clock.
    input wire logic sys_rst,   // Synchronous reset, active high.
    input wire logic run,       // Timer counts while high.
    output logic tick           // One-cycle pulse per interval.
);
    localparam int TICK_GAP = REFRESH_CYC; // Cycles between ticks.

    logic [8:0] cnt_reg; // Cycles left until the next tick.

    // -----------------------------------------------------------------
    // Down counter.
    // -----------------------------------------------------------------
    // Interval countdown.
    always_ff @(posedge clk) begin
        if (sys_rst || !run || cnt_reg == 9'h0) begin
            cnt_reg <= 9'(REFRESH_CYC - 1);
        end else begin
            cnt_reg <= cnt_reg - 9'h1;
        end
    end

    assign tick = run && (cnt_reg == 9'h0);

    tick_period_a: assert property (@(posedge clk) disable iff (sys_rst || !run)
        tick |-> ##[TICK_GAP:TICK_GAP] tick)
        else $error("refresh tick spacing wrong");

endmodule

// *** core/cas_read_sampler.sv ***
// Samples read data a fixed CAS latency after each read column strobe.
// Assumes the SDRAM and the strobe share the system clock.
`timescale 1ns/10ps
module cas_read_sampler
    import sdram_seq_pkg::*;
(
    input wire logic clk,            // System clock.
    input wire logic sys_rst,        // Synchronous reset, active high.
    input wire logic col_rd,         // Read column strobe, one-cycle pulse.
    input wire logic [15:0] dq_in,   // SDRAM data lines.
    output logic [15:0] rd_data,     // Captured read data.
    output logic rd_valid            // One-cycle pulse with rd_data.
);
    logic [CAS_LAT-2:0] dly_reg; // Strobe delay line.

    // -----------------------------------------------------------------
    // Latency delay line and capture.
    // -----------------------------------------------------------------
    // Sample after latency.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dly_reg <= '0;
            rd_valid <= 1'b0;
            rd_data <= 16'h0;
        end else begin
            dly_reg <= {dly_reg[CAS_LAT-3:0], col_rd};
            rd_valid <= dly_reg[CAS_LAT-2];
            if (dly_reg[CAS_LAT-2]) begin
                rd_data <= dq_in;
            end
        end
    end

    cas_sample_a: assert property (@(posedge clk) disable iff (sys_rst)
        col_rd |-> ##3 (rd_valid && rd_data == $past(dq_in)))
        else $error("read data not sampled three cycles after strobe");

endmodule

// *** core/sdram_init_refresh_sequencer.sv ***
// SDRAM bring-up and refresh sequencer with an Avalon-MM register slave.
// Assumes a shared 40 MHz clock with the SDRAM and the bus controller.
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
module sdram_init_refresh_sequencer
    import sdram_seq_pkg::*;
(
    input wire logic clk,                 // System clock.
    input wire logic sys_rst,             // Synchronous reset, active high.
    input wire logic [3:0] avs_address,   // Byte address of the register.
    input wire logic avs_read,            // Read request.
    input wire logic avs_write,           // Write request.
    input wire logic [31:0] avs_writedata, // Write data.
    output logic [31:0] avs_readdata,     // Read data, registered.
    output logic avs_waitrequest,         // Stall while the answer is prepared.
    input wire logic bus_busy,            // A bus transfer is in progress.
    input wire logic col_rd,              // Read column strobe from the access path.
    input wire logic [15:0] dq_in,        // SDRAM data lines.
    output logic sd_cs_n,                 // SDRAM chip select, active low.
    output logic sd_ras_n,                // Row strobe, active low.
    output logic sd_cas_n,                // Column strobe, active low.
    output logic sd_we_n,                 // Write enable, active low.
    output logic [11:0] sd_addr,          // SDRAM address lines.
    output logic [31:0] proc_addr,        // Same address as seen on the processor bus.
    output logic [15:0] rd_data,          // Read data at CAS latency.
    output logic rd_valid,                // Read data valid pulse.
    output logic init_done                // Bring-up finished.
);

    // -----------------------------------------------------------------
    // Declarations.
    // -----------------------------------------------------------------
    seq_state_type state_reg;   // Sequencer state.
    logic [7:0] gap_reg;        // Cycles to wait before the next command.
    logic [3:0] ref_left_reg;   // Bring-up refreshes still to issue.
    logic [3:0] pend_reg;       // Owed periodic refreshes.
    logic ovf_reg;              // Sticky: owed refreshes overflowed.
    logic wb_reg;               // Write-burst choice for the mode word.
    logic ren_reg;              // Periodic refresh enable.
    logic [11:0] mode_reg;      // Mode word last loaded.
    logic [15:0] rcnt_reg;      // Refresh commands issued.
    logic [3:0] cmd_reg;        // Command on the pins.
    logic [11:0] addr_reg;      // Address on the pins.
    logic [31:0] paddr_reg;     // Processor-bus view of the address.
    logic ack_reg;              // Bus answer phase.
    logic [31:0] rdata_reg;     // Read data register.
    logic [3:0] cmd_next;       // Command to issue at the next edge.
    logic [11:0] addr_next;     // Address to issue with it.
    logic can_issue;            // Gap elapsed and bus free.
    logic run_ref;              // Periodic refresh goes out now.
    logic tick;                 // Refresh interval elapsed.
    logic start;                // Software asked for bring-up.
    logic wr_ok;                // A write takes effect this edge.
    logic [31:0] rd_word;       // Selected register for a read.
    logic [3:0] ref_seen_reg;   // Refreshes since the last precharge, for checking.

    // True when the bus address selects the given register.
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        return a == ofs;
    endfunction

    // -----------------------------------------------------------------
    // Avalon-MM slave.
    // -----------------------------------------------------------------
    // Every access stalls exactly one cycle; the answer is then registered.
    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
    assign wr_ok = avs_write && ack_reg;
    assign start = wr_ok && hit(avs_address, CTRL_OFS) && avs_writedata[CTRL_START_BIT];
    assign avs_readdata = rdata_reg;

    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        rd_word = 32'h0;
        if (hit(avs_address, CTRL_OFS)) begin
            rd_word[CTRL_WB_BIT] = wb_reg;
            rd_word[CTRL_REN_BIT] = ren_reg;
        end else if (hit(avs_address, STAT_OFS)) begin
            rd_word[STAT_DONE_BIT] = (state_reg == ST_RUN);
            rd_word[STAT_INIT_BIT] = (state_reg != ST_RUN) && (state_reg != ST_IDLE);
            rd_word[STAT_PEND_LSB +: 4] = pend_reg;
            rd_word[STAT_OVF_BIT] = ovf_reg;
        end else if (hit(avs_address, RCNT_OFS)) begin
            rd_word[15:0] = rcnt_reg;
        end else if (hit(avs_address, MODE_OFS)) begin
            rd_word[11:0] = mode_reg;
        end
    end

    // Answer phase and read capture.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
            if (avs_read && !ack_reg) begin
                rdata_reg <= rd_word;
            end
        end
    end

    // -----------------------------------------------------------------
    // Control settings.
    // -----------------------------------------------------------------
    // The write-burst choice is only taken into the SDRAM at mode set, so
    // software must settle it before asking for bring-up.
    // Settings precede mode set.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_reg <= CTRL_WB_RST;
            ren_reg <= CTRL_REN_RST;
        end else if (wr_ok && hit(avs_address, CTRL_OFS)) begin
            wb_reg <= avs_writedata[CTRL_WB_BIT];
            ren_reg <= avs_writedata[CTRL_REN_BIT];
        end
    end

    // -----------------------------------------------------------------
    // Command selection.
    // -----------------------------------------------------------------
    assign can_issue = (gap_reg == 8'h0) && !bus_busy;
    assign run_ref = (state_reg == ST_RUN) && ren_reg && (pend_reg != 4'h0) && can_issue;

    // Decides the command for the next edge from the current state.
    always_comb begin
        cmd_next = CMD_NOP;
        addr_next = 12'h0;
        case (state_reg)
            ST_PRE: begin
                if (can_issue) begin
                    cmd_next = CMD_PRE;
                    addr_next[PRE_ALL_BIT] = 1'b1;
                end
            end
            ST_REF: begin
                if (can_issue) begin
                    cmd_next = CMD_REF;
                end
            end
            ST_MRS: begin
                if (can_issue) begin
                    cmd_next = CMD_MRS;
                    addr_next = mode_word(wb_reg);
                end
            end
            ST_RUN: begin
                if (run_ref) begin
                    cmd_next = CMD_REF;
                end
            end
            default: begin
                cmd_next = CMD_NOP;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // Bring-up sequence.
    // -----------------------------------------------------------------
    // Strict bring-up order.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            ref_left_reg <= 4'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        state_reg <= ST_PRE;
                    end
                end
                ST_PRE: begin
                    if (can_issue) begin
                        state_reg <= ST_REF;
                        ref_left_reg <= 4'(INIT_REFRESHES);
                    end
                end
                ST_REF: begin
                    if (can_issue) begin
                        ref_left_reg <= ref_left_reg - 4'h1;
                        if (ref_left_reg == 4'h1) begin
                            state_reg <= ST_MRS;
                        end
                    end
                end
                ST_MRS: begin
                    if (can_issue) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // A new start re-runs the whole bring-up.
                    if (start) begin
                        state_reg <= ST_PRE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Spacing between commands.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gap_reg <= 8'h0;
        end else if (cmd_next != CMD_NOP) begin
            gap_reg <= 8'(GAP_CYC - 1);
        end else if (gap_reg != 8'h0) begin
            gap_reg <= gap_reg - 8'h1;
        end
    end

    // -----------------------------------------------------------------
    // Periodic refresh bookkeeping.
    // -----------------------------------------------------------------
    refresh_timer timer_u (
        .clk(clk),
        .sys_rst(sys_rst),
        .run((state_reg == ST_RUN) && ren_reg),
        .tick(tick)
    );

    // Owed refreshes accumulate while the bus is busy, so late commands
    // catch up in a burst; the sweep of all rows takes just under the
    // retention window, about 33.6 ms of 34 ms, which is the slack this depends on.
    // Owed refresh catch-up.
    always_ff @(posedge clk) begin
        if (sys_rst || state_reg != ST_RUN) begin
            pend_reg <= 4'h0;
        end else if (tick && !run_ref && pend_reg != PEND_MAX) begin
            pend_reg <= pend_reg + 4'h1;
        end else if (!tick && run_ref) begin
            pend_reg <= pend_reg - 4'h1;
        end
    end

    // Overflow is sticky; a set in the clearing cycle wins.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ovf_reg <= 1'b0;
        end else if (tick && !run_ref && pend_reg == PEND_MAX) begin
            ovf_reg <= 1'b1;
        end else if (wr_ok && hit(avs_address, STAT_OFS) && avs_writedata[STAT_OVF_BIT]) begin
            ovf_reg <= 1'b0;
        end
    end

    // Count of refresh commands, bring-up ones included.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rcnt_reg <= 16'h0;
        end else if (cmd_next == CMD_REF) begin
            rcnt_reg <= rcnt_reg + 16'h1;
        end
    end

    // -----------------------------------------------------------------
    // SDRAM pins.
    // -----------------------------------------------------------------
    // Processor-bus address shift.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd_reg <= CMD_NOP;
            addr_reg <= 12'h0;
            paddr_reg <= 32'h0;
        end else begin
            cmd_reg <= cmd_next;
            addr_reg <= addr_next;
            paddr_reg <= {17'h0, addr_next, 3'h0};
        end
    end

    // Mode word kept for readback.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_reg <= 12'h0;
        end else if (cmd_next == CMD_MRS) begin
            mode_reg <= addr_next;
        end
    end

    assign {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} = cmd_reg;
    assign sd_addr = addr_reg;
    assign proc_addr = paddr_reg;
    assign init_done = (state_reg == ST_RUN);

    cas_read_sampler sampler_u (
        .clk(clk),
        .sys_rst(sys_rst),
        .col_rd(col_rd),
        .dq_in(dq_in),
        .rd_data(rd_data),
        .rd_valid(rd_valid)
    );

    // -----------------------------------------------------------------
    // Checks.
    // -----------------------------------------------------------------
    // Refreshes seen on the pins since the last precharge.
    always_ff @(posedge clk) begin
        if (sys_rst || cmd_reg == CMD_PRE) begin
            ref_seen_reg <= 4'h0;
        end else if (cmd_reg == CMD_REF && ref_seen_reg != 4'hf) begin
            ref_seen_reg <= ref_seen_reg + 4'h1;
        end
    end

    init_order_a: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_reg == CMD_MRS |-> ref_seen_reg == 4'(INIT_REFRESHES))
        else $error("mode set not preceded by eight refreshes");
    mode_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_reg == CMD_MRS |-> sd_addr == mode_reg && mode_reg == {2'h0, $past(wb_reg), 9'h32})
        else $error("mode word not on address lines");
    reserved_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_reg == CMD_MRS |-> {sd_addr[11:10], sd_addr[8:7]} == 4'h0)
        else $error("reserved mode bits not zero");
    wb_select_a: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_reg == CMD_MRS |-> sd_addr[9] == $past(wb_reg))
        else $error("write-burst bit wrong");
    cas_field_a: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_reg == CMD_MRS |-> sd_addr[6:4] == 3'h3)
        else $error("CAS latency field wrong");
    burst_field_a: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_reg == CMD_MRS |-> sd_addr[3:0] == 4'h2)
        else $error("burst fields wrong");
    proc_shift_a: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_reg == CMD_MRS |-> proc_addr[14:3] == mode_reg && proc_addr[2:0] == 3'h0)
        else $error("processor address shift wrong");
    pend_issue_a: assert property (@(posedge clk) disable iff (sys_rst)
        run_ref |=> cmd_reg == CMD_REF && $past(pend_reg) != 4'h0)
        else $error("pending refresh not issued");
    busy_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(cmd_reg == CMD_REF) |-> !$past(bus_busy))
        else $error("refresh issued during busy bus");

endmodule

// *** test/sdram_model.sv ***
// SDRAM array model: decodes the command pins and logs bring-up and refresh.
// Assumes it shares the sequencer clock and sees the bus busy flag.
`timescale 1ns/10ps
module sdram_model (
    input wire logic clk, // System clock.
    input wire logic sys_rst, // Reset, active high.
    input wire logic [3:0] cmd, // Command as {cs_n, ras_n, cas_n, we_n}.
    input wire logic [11:0] addr, // Address lines.
    input wire logic bus_busy, // Bus transfer in progress.
    output logic [15:0] dq, // Data lines, changing every cycle.
    output logic [3:0] n_ref, // Refreshes since the last precharge.
    output logic [11:0] mode_q, // Last loaded mode word.
    output logic [15:0] gap, // Cycles between the last two refreshes.
    output logic bad // Set when an order or bus rule is broken.
);
    logic [15:0] cyc, last; // Free cycle count and time of last refresh.
    logic busy_q, pre_ok; // Busy one cycle ago; valid precharge-all seen.
    // ------------------------------------------------------------
    // Command decoder.
    // ------------------------------------------------------------
    // The data never holds still, so a late sample cannot match by luck.
    always @(posedge clk) begin
        cyc <= cyc + 16'h1;
        dq <= dq + 16'h3b5d;
        busy_q <= bus_busy;
        if (sys_rst) begin
            {cyc, last, gap, n_ref, mode_q, bad, pre_ok} <= '0;
            dq <= 16'h1234;
        end else begin
            case (cmd)
                4'h2: begin
                    pre_ok <= addr[10];
                    n_ref <= 4'h0;
                end
                4'h1: begin
                    n_ref <= n_ref + 4'h1;
                    gap <= cyc - last;
                    last <= cyc;
                end
                4'h0: begin
                    bad <= bad | !pre_ok | (n_ref != 4'h8);
                    mode_q <= addr;
                end
                default: ;
            endcase
            if (cmd != 4'h7 && busy_q)
                bad <= 1'b1;
        end
    end
endmodule

// *** test/tb_sdram_init_refresh_sequencer.sv ***
// Testbench: bring-up twice, periodic and held refresh, read latency.
// Assumes the sequencer's register map and the model's logs.
`timescale 1ns/10ps
module tb_sdram_init_refresh_sequencer
    import sdram_seq_pkg::*;
;
    logic clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, bus_busy = 0, col_rd = 0, wb;
    logic [3:0] avs_address = 4'h0, n_ref, r0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rdv, proc_addr, mrs_proc;
    logic avs_waitrequest, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n, rd_valid, init_done, bad;
    logic [11:0] sd_addr, mode_q;
    logic [15:0] dq_in, rd_data, gap, exp16;
    int fails = 0, compares = 0, cycles = 0, seed = 58476;
    always #12.5 clk = ~clk;
    sdram_init_refresh_sequencer dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus_busy(bus_busy),
        .col_rd(col_rd), .dq_in(dq_in), .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n),
        .sd_we_n(sd_we_n), .sd_addr(sd_addr), .proc_addr(proc_addr), .rd_data(rd_data),
        .rd_valid(rd_valid), .init_done(init_done));
    sdram_model mem (.clk(clk), .sys_rst(sys_rst), .cmd({sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n}),
        .addr(sd_addr), .bus_busy(bus_busy), .dq(dq_in), .n_ref(n_ref), .mode_q(mode_q), .gap(gap), .bad(bad));
    // Keep the processor-side address seen with each mode set.
    always @(posedge clk) begin
        if ({sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} == 4'h0)
            mrs_proc <= proc_addr;
    end
    // Expected mode word: CAS latency 3, sequential, four beats.
    function automatic logic [11:0] want_mode(input logic wsel);
        return {2'h0, wsel, 2'h0, 3'h3, 1'h0, 3'h2};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // One Avalon access, held until waitrequest is seen low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // Only the bench timeout ends a wait that never gets its answer.
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rdv = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("Counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // A hang is cut short and counted as a failure.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        bus(1'b0, 4'h0, 32'h0);
        check(rdv, 32'h4);
        bus(1'b0, 4'h2, 32'h0);
        check(rdv, 32'h0);
        for (int i = 0; i < 2; i++) begin
            // Both write-burst choices are covered, the first one drawn at random.
            wb = (i == 0) ? 1'($random(seed)) : !wb;
            bus(1'b1, 4'h0, {29'h0, 1'b1, wb, 1'b1});
            repeat (2) @(posedge clk);
            for (int k = 0; k < 900 && init_done !== 1'b1; k++) begin
                bus_busy <= 1'($random(seed));
                @(posedge clk);
            end
            bus_busy <= 1'b0;
            // The model logs the mode set one edge after it reaches the pins.
            @(posedge clk);
            check(init_done, 1'b1);
            check(n_ref, INIT_REFRESHES);
            check(mode_q, want_mode(wb));
            check(mrs_proc, {17'h0, want_mode(wb), 3'h0});
            bus(1'b0, 4'hc, 32'h0);
            check(rdv, want_mode(wb));
            r0 = n_ref;
            for (int k = 0; k < 900 && n_ref !== 4'(r0 + 2); k++)
                @(posedge clk);
            check(gap, REFRESH_CYC);
            check(32'(gap) * 4096 * CLK_NS <= 34000000, 1'b1);
            // A tick while the bus is held must wait, then go out at once.
            bus_busy <= 1'b1;
            r0 = n_ref;
            repeat (400) @(posedge clk);
            bus(1'b0, 4'h4, 32'h0);
            check(rdv[7:4], 4'h1);
            check(n_ref, r0);
            bus_busy <= 1'b0;
            repeat (4) @(posedge clk);
            check(n_ref, 4'(r0 + 1));
            check(bad, 1'b0);
            // Bring-up refreshes plus two periodic ones and the held one, per pass.
            bus(1'b0, 4'h8, 32'h0);
            check(rdv, 32'((INIT_REFRESHES + 3) * (i + 1)));
            col_rd <= 1'b1;
            @(posedge clk);
            col_rd <= 1'b0;
            repeat (2) @(posedge clk);
            exp16 = dq_in;
            #1;
            check(rd_valid, 1'b1);
            check(rd_data, exp16);
            $display("Bring-up and refresh test %0d done", i);
        end
        give_verdict();
    end
endmodule
